/* File: logic/epc_counter.sv */
// Purpose: encoder, hall sensor and timer counter, 16-bit in the position modes, 24-bit in the timer modes
// Assumes: phase inputs are already synchronous and filtered
// Notes: hall inputs U,V,W share the A,B,Z pins
//
// Added by the designer: the register offsets and the strobed register port.
`include "epc_params.svh"
`default_nettype none

module epc_counter (
    input wire logic CLK,
    input wire logic RST,
    input wire epc_pkg::epc_bus_t BUS,
    output logic [31:0] RDATA,
    input wire epc_pkg::epc_phase_t PHASE,
    output logic DIR_FLAG,
    output logic DIVIDED_PULSE_OUT,
    output logic IRQ_EVENT,
    output logic IRQ_CMP
);
    import epc_pkg::*;

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    logic run_r, zen_r, zesel_r, cmpen_r, three_phase_enable_r;
    epc_mode_t mode_r;
    epc_tclr_t tclr_r;
    logic [15:0] wrap_r;
    logic [23:0] cmp_r;
    logic [15:0] div_r;
    logic [23:0] cnt_r, cnt_nxt;
    logic [23:0] cap_r;
    logic dir_r, rev_err_r, idx_seen_r, cmp_flag_r;
    logic [15:0] div_cnt_r;
    logic div_out_r;
    epc_phase_t ph_r;
    logic [31:0] rdata_r;
    logic wr_ctrl, wr_wrap, wr_cmp, wr_div, rd_stat;
    logic clr_req, sftcap_req;

    always_comb begin
        wr_ctrl = 1'b0;
        wr_wrap = 1'b0;
        wr_cmp = 1'b0;
        wr_div = 1'b0;
        rd_stat = 1'b0;
        if (BUS.wr && BUS.addr == `EPC_OFF_CTRL) begin
            wr_ctrl = 1'b1;
        end else if (BUS.wr && BUS.addr == `EPC_OFF_WRAP) begin
            wr_wrap = 1'b1;
        end else if (BUS.wr && BUS.addr == `EPC_OFF_CMP) begin
            wr_cmp = 1'b1;
        end else if (BUS.wr && BUS.addr == `EPC_OFF_DIV) begin
            wr_div = 1'b1;
        end else if (BUS.rd && BUS.addr == `EPC_OFF_STAT) begin
            rd_stat = 1'b1;
        end
    end

    assign clr_req = wr_ctrl && BUS.wdata[`EPC_CTRL_CLR];
    assign sftcap_req = wr_ctrl && BUS.wdata[`EPC_CTRL_SFTCAP];

    always_ff @(posedge CLK) begin
        if (RST) begin
            run_r <= 1'b0;
            zen_r <= 1'b0;
            zesel_r <= 1'b0;
            cmpen_r <= 1'b0;
            three_phase_enable_r <= 1'b0;
            mode_r <= EPC_ENCODER;
            tclr_r <= EPC_TCLR_FREE;
        end else if (wr_ctrl) begin
            run_r <= BUS.wdata[`EPC_CTRL_RUN];
            zen_r <= BUS.wdata[`EPC_CTRL_ZEN];
            zesel_r <= BUS.wdata[`EPC_CTRL_ZESEL];
            cmpen_r <= BUS.wdata[`EPC_CTRL_CMPEN];
            three_phase_enable_r <= BUS.wdata[`EPC_CTRL_THREE_PHASE_ENABLE];
            mode_r <= epc_mode_t'(BUS.wdata[`EPC_CTRL_MODE_HI:`EPC_CTRL_MODE_LO]);
            tclr_r <= epc_tclr_t'(BUS.wdata[`EPC_CTRL_TCLR_HI:`EPC_CTRL_TCLR_LO]);
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            wrap_r <= `EPC_WRAP_RST;
            cmp_r <= 24'h000000;
            div_r <= 16'h0000;
        end else begin
            if (wr_wrap) begin
                wrap_r <= BUS.wdata[15:0];
            end
            if (wr_cmp) begin
                cmp_r <= BUS.wdata[23:0];
            end
            if (wr_div) begin
                div_r <= BUS.wdata[15:0];
            end
        end
    end

    // ----------------------------------------
    // phase decode
    // ----------------------------------------
    function automatic logic [1:0] quad_state(input logic a, input logic b);
        quad_state = {b, a ^ b};
    endfunction

    // hall position 0..5 for three-phase, -1 (7) for invalid
    function automatic logic [2:0] hall_pos(input logic u, input logic v, input logic w);
        case ({u, v, w})
            3'b100: hall_pos = 3'h0;
            3'b110: hall_pos = 3'h1;
            3'b010: hall_pos = 3'h2;
            3'b011: hall_pos = 3'h3;
            3'b001: hall_pos = 3'h4;
            3'b101: hall_pos = 3'h5;
            default: hall_pos = 3'h7;
        endcase
    endfunction

    logic [1:0] qs_now, qs_old;
    logic [2:0] hp_now, hp_old;
    logic step, step_fwd;
    logic z_rise, z_fall, idx_edge, quad_mode, sens_mode;

    always_ff @(posedge CLK) begin
        if (RST) begin
            ph_r <= '0;
        end else begin
            ph_r <= PHASE;
        end
    end

    assign quad_mode = (mode_r == EPC_ENCODER) || ((mode_r != EPC_TIMER) && !three_phase_enable_r);
    assign sens_mode = (mode_r == EPC_SENS_EVENT) || (mode_r == EPC_SENS_TIMER);
    assign z_rise = PHASE.z && !ph_r.z;
    assign z_fall = !PHASE.z && ph_r.z;

    always_comb begin
        qs_now = quad_state(PHASE.a, PHASE.b);
        qs_old = quad_state(ph_r.a, ph_r.b);
        hp_now = hall_pos(PHASE.a, PHASE.b, PHASE.z);
        hp_old = hall_pos(ph_r.a, ph_r.b, ph_r.z);
        step = 1'b0;
        step_fwd = 1'b0;
        if (quad_mode) begin
            // four states per cycle, one pulse per edge
            step = (qs_now != qs_old);
            step_fwd = (qs_now == qs_old + 2'd1);
        end else if (sens_mode && hp_now != 3'h7 && hp_old != 3'h7) begin
            // six states per cycle
            step = (hp_now != hp_old);
            step_fwd = (hp_now == ((hp_old == 3'h5) ? 3'h0 : hp_old + 3'h1));
        end
        step = step && run_r && mode_r != EPC_TIMER;
    end

    // index edge follows the rotation direction
    assign idx_edge = zen_r && (mode_r == EPC_ENCODER) && (dir_r ? z_rise : z_fall);

    // ----------------------------------------
    // direction and status flags
    // ----------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            dir_r <= 1'b0;
        end else if (!run_r) begin
            dir_r <= 1'b0;
        end else if (step) begin
            dir_r <= step_fwd;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            rev_err_r <= 1'b0;
        end else if (step && mode_r == EPC_SENS_TIMER && step_fwd != dir_r) begin
            rev_err_r <= 1'b1; // set wins over read clear
        end else if (rd_stat) begin
            rev_err_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            idx_seen_r <= 1'b0;
        end else if (idx_edge) begin
            idx_seen_r <= 1'b1;
        end else if (!run_r) begin
            idx_seen_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // counter
    // ----------------------------------------
    logic timer_trig;
    assign timer_trig = zen_r && (zesel_r ? z_fall : z_rise);

    always_comb begin
        cnt_nxt = cnt_r;
        case (mode_r)
            EPC_ENCODER: begin
                if (idx_edge) begin
                    cnt_nxt = 24'h000000;
                end else if (step && step_fwd) begin
                    cnt_nxt = (cnt_r[15:0] == wrap_r) ? 24'h000000 : cnt_r + 24'h000001;
                end else if (step) begin
                    cnt_nxt = (cnt_r[15:0] == 16'h0000) ? {8'h00, wrap_r} : cnt_r - 24'h000001;
                end
            end
            EPC_SENS_EVENT: begin
                if (step && step_fwd) begin
                    cnt_nxt = {8'h00, cnt_r[15:0] + 16'h0001};
                end else if (step) begin
                    cnt_nxt = {8'h00, cnt_r[15:0] - 16'h0001};
                end
            end
            EPC_SENS_TIMER: begin
                cnt_nxt = step ? 24'h000000 : cnt_r + 24'h000001;
            end
            default: begin
                cnt_nxt = cnt_r + 24'h000001;
                if (tclr_r == EPC_TCLR_CMP && cnt_r == cmp_r) begin
                    cnt_nxt = 24'h000000;
                end else if (tclr_r == EPC_TCLR_TRIG && timer_trig) begin
                    cnt_nxt = 24'h000000;
                end
            end
        endcase
        if (clr_req) begin
            cnt_nxt = 24'h000000;
        end
        if (mode_r == EPC_ENCODER || mode_r == EPC_SENS_EVENT) begin
            cnt_nxt[23:16] = 8'h00;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            cnt_r <= 24'h000000;
        end else if (run_r || clr_req) begin
            cnt_r <= cnt_nxt;
        end
    end

    // ----------------------------------------
    // capture
    // ----------------------------------------
    logic cap_event;
    assign cap_event = (mode_r == EPC_SENS_TIMER && step) || (mode_r == EPC_TIMER && timer_trig && run_r);

    always_ff @(posedge CLK) begin
        if (RST) begin
            cap_r <= 24'h000000;
        end else if (cap_event) begin
            cap_r <= cnt_r;
        end else if (sftcap_req && (mode_r == EPC_SENS_TIMER || mode_r == EPC_TIMER)) begin
            cap_r <= cnt_r;
        end
    end

    // ----------------------------------------
    // divided pulse and interrupts
    // ----------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            div_cnt_r <= 16'h0000;
            div_out_r <= 1'b0;
        end else if (step) begin
            if (div_cnt_r >= div_r) begin
                div_cnt_r <= 16'h0000;
                div_out_r <= !div_out_r;
            end else begin
                div_cnt_r <= div_cnt_r + 16'h0001;
            end
        end
    end

    logic cmp_hit, cmp_gate;
    assign cmp_gate = !(mode_r == EPC_ENCODER && zen_r && !idx_seen_r);
    assign cmp_hit = run_r && cmpen_r && cmp_gate && (cnt_r == cmp_r);

    always_ff @(posedge CLK) begin
        if (RST) begin
            cmp_flag_r <= 1'b0;
        end else begin
            cmp_flag_r <= cmp_hit;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            IRQ_EVENT <= 1'b0;
            IRQ_CMP <= 1'b0;
        end else begin
            IRQ_EVENT <= step || (mode_r == EPC_TIMER && timer_trig && run_r);
            IRQ_CMP <= cmp_hit && !cmp_flag_r;
        end
    end

    assign DIR_FLAG = dir_r;
    assign DIVIDED_PULSE_OUT = div_out_r;

    // ----------------------------------------
    // read port
    // ----------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata_r <= 32'h00000000;
        end else if (BUS.rd) begin
            if (BUS.addr == `EPC_OFF_CTRL) begin
                rdata_r <= {20'h00000, tclr_r, 3'b000, mode_r, three_phase_enable_r, cmpen_r, zesel_r, zen_r, run_r};
            end else if (BUS.addr == `EPC_OFF_STAT) begin
                rdata_r <= {28'h0000000, idx_seen_r, rev_err_r, cmp_flag_r, dir_r};
            end else if (BUS.addr == `EPC_OFF_WRAP) begin
                rdata_r <= {16'h0000, wrap_r};
            end else if (BUS.addr == `EPC_OFF_CMP) begin
                rdata_r <= {8'h00, cmp_r};
            end else if (BUS.addr == `EPC_OFF_CNT) begin
                // timer modes show the capture, others the live count
                rdata_r <= (mode_r == EPC_SENS_TIMER || mode_r == EPC_TIMER) ? {8'h00, cap_r} :
                    {16'h0000, cnt_r[15:0]};
            end else if (BUS.addr == `EPC_OFF_DIV) begin
                rdata_r <= {16'h0000, div_r};
            end else begin
                rdata_r <= 32'h00000000;
            end
        end else begin
            rdata_r <= 32'h00000000;
        end
    end
    assign RDATA = rdata_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    AST_CLR_ZERO: assert property (clr_req |=> cnt_r == 24'h000000) else $error("clear failed");
    AST_ENC_WRAP: assert property (mode_r == EPC_ENCODER && run_r && step && step_fwd && !idx_edge && !clr_req
        && cnt_r[15:0] == wrap_r && !wr_ctrl |=> cnt_r == 24'h000000) else $error("wrap failed");
    AST_ENC_RELOAD: assert property (mode_r == EPC_ENCODER && run_r && step && !step_fwd && !idx_edge
        && !clr_req && cnt_r == 24'h000000 && !wr_ctrl && !wr_wrap |=> cnt_r == {8'h00, wrap_r})
        else $error("reload failed");
    AST_IDX_CLR: assert property (idx_edge && run_r && !wr_ctrl |=> cnt_r == 24'h000000) else $error("index");
    AST_UPPER_ZERO: assert property (mode_r == EPC_SENS_EVENT && !$past(wr_ctrl) |-> cnt_r[23:16] == 8'h00)
        else $error("upper bits");
    AST_ST_CLR: assert property (mode_r == EPC_SENS_TIMER && step && !wr_ctrl |=> cnt_r == 24'h000000 &&
        cap_r == $past(cnt_r)) else $error("timer count pulse");
    AST_IRQ_PULSE: assert property (IRQ_CMP |=> !IRQ_CMP) else $error("compare irq not a pulse");
    AST_CMP_GATE: assert property (mode_r == EPC_ENCODER && zen_r && !idx_seen_r |=> !IRQ_CMP)
        else $error("compare irq before index");
    AST_EVT_IRQ: assert property (step |=> IRQ_EVENT) else $error("event irq missing");
    AST_TMR_RUN: assert property (mode_r == EPC_TIMER && run_r && tclr_r == EPC_TCLR_FREE && !wr_ctrl
        |=> cnt_r == $past(cnt_r) + 24'h000001) else $error("timer not counting");

    COV_ENC_UP: cover property (mode_r == EPC_ENCODER && step && step_fwd);
    COV_IDX: cover property (idx_edge && step);
    COV_REV: cover property (rev_err_r);
    COV_CAP: cover property (cap_event);
endmodule
`default_nettype wire

/* File: logic/epc_params.svh */
// Purpose: constants for the encoder position counter
// Assumes: 100 MHz system clock
// Notes: register byte offsets are word aligned
`ifndef EPC_PARAMS_SVH
`define EPC_PARAMS_SVH
`define EPC_OFF_CTRL 8'h00
`define EPC_OFF_STAT 8'h04
`define EPC_OFF_WRAP 8'h08
`define EPC_OFF_CMP 8'h0c
`define EPC_OFF_CNT 8'h10
`define EPC_OFF_DIV 8'h14
`define EPC_CTRL_RUN 0
`define EPC_CTRL_ZEN 1
`define EPC_CTRL_ZESEL 2
`define EPC_CTRL_CMPEN 3
`define EPC_CTRL_THREE_PHASE_ENABLE 4
`define EPC_CTRL_MODE_LO 5
`define EPC_CTRL_MODE_HI 6
`define EPC_CTRL_CLR 8
`define EPC_CTRL_SFTCAP 9
`define EPC_CTRL_TCLR_LO 10
`define EPC_CTRL_TCLR_HI 11
`define EPC_WRAP_RST 16'hffff
`define EPC_MAX16 16'hffff
`define EPC_MAX24 24'hffffff
`endif

/* File: logic/epc_pkg.sv */
// Purpose: types for the encoder position counter
// Assumes: nothing
// Notes: none
`default_nettype none
package epc_pkg;
    typedef enum logic [1:0] {
        EPC_ENCODER,
        EPC_SENS_EVENT,
        EPC_SENS_TIMER,
        EPC_TIMER
    } epc_mode_t;
    typedef enum logic [1:0] {
        EPC_TCLR_FREE,
        EPC_TCLR_SOFT,
        EPC_TCLR_CMP,
        EPC_TCLR_TRIG
    } epc_tclr_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } epc_bus_t;
    typedef struct packed {
        logic a;
        logic b;
        logic z;
    } epc_phase_t;
endpackage
`default_nettype wire

/* File: testbench/encoder_position_counter_test.sv */
// Purpose: self-checking bench for the encoder position counter
// Assumes: phase source model drives the sensor pins
// Notes: expected counts come from an integer model in the bench
`include "epc_params.svh"
`default_nettype none
module encoder_position_counter_test;
    timeunit 1ns;
    timeprecision 1ps;
    import epc_pkg::*;
    localparam logic [6:0] RUN = 7'h01, ZEN = 7'h02, CMPEN = 7'h08, P3 = 7'h10, CLR = 7'h20, CAP = 7'h40;
    logic clk, rst, step, cw, three_ph, idx, dir, dpo, dpo_q, irq_ev, irq_cmp, c;
    epc_bus_t bus;
    epc_phase_t phase;
    logic [31:0] rdata, d, d2;
    int num_errors = 0, checks_done = 0, cyc = 0, ev_n = 0, cmp_n = 0, tog_n = 0, exp_cnt, w, e0, t0;
    epc_counter u_dut (.CLK(clk), .RST(rst), .BUS(bus), .RDATA(rdata), .PHASE(phase), .DIR_FLAG(dir),
        .DIVIDED_PULSE_OUT(dpo), .IRQ_EVENT(irq_ev), .IRQ_CMP(irq_cmp));
    epc_enc_model u_enc (.CLK(clk), .STEP(step), .CW(cw), .THREE_PH(three_ph), .IDX(idx), .PHASE(phase));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ----------------------------------------------------------------
    // pulse counters and hang guard
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        cyc++;
        ev_n += int'(irq_ev === 1'b1);
        cmp_n += int'(irq_cmp === 1'b1);
        tog_n += int'(dpo !== dpo_q);
        dpo_q = dpo;
        if (cyc == 6000) begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        @(negedge clk);
        v = rdata;
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk(nm, exp, v);
    endtask
    task automatic move(input logic go, input logic cwise, input logic z);
        @(posedge clk);
        step <= go;
        cw <= cwise;
        idx <= z;
        @(posedge clk);
        step <= 1'b0;
        repeat (5) @(posedge clk);
    endtask
    // control word: cap, clr, three_phase_enable, cmpen, zesel, zen, run from high to low
    function automatic logic [31:0] ctl(input epc_mode_t md, input logic [6:0] f);
        return {22'h0, f[6:5], 1'b0, md, f[4:0]};
    endfunction
    // ----------------------------------------------------------------
    // stimulus
    // ----------------------------------------------------------------
    initial begin
        rst = 1'b1;
        {step, cw, three_ph, idx} = 4'h0;
        bus = '0;
        void'($urandom(32'h2979));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rchk("count reset", `EPC_OFF_CNT, 32'h0);
        rchk("wrap reset", `EPC_OFF_WRAP, 32'(`EPC_WRAP_RST));
        rchk("unmapped", 8'h3c, 32'h0);
        wr(`EPC_OFF_CMP, 32'h2);
        wr(`EPC_OFF_CTRL, ctl(EPC_ENCODER, RUN | CMPEN | CLR));
        e0 = cmp_n;
        repeat (3) move(1'b1, 1'b1, 1'b0);
        chk("compare pulses", 32'(e0 + 1), 32'(cmp_n));
        wr(`EPC_OFF_CTRL, ctl(EPC_ENCODER, RUN | CLR));
        rchk("cleared", `EPC_OFF_CNT, 32'h0);
        wr(`EPC_OFF_CTRL, ctl(EPC_ENCODER, RUN | ZEN));
        repeat (3) move(1'b1, 1'b1, 1'b0);
        move(1'b0, 1'b1, 1'b1);
        rchk("index rise", `EPC_OFF_CNT, 32'h0);
        repeat (3) move(1'b1, 1'b1, 1'b1);
        move(1'b1, 1'b0, 1'b1);
        move(1'b1, 1'b0, 1'b0);
        rchk("index with step", `EPC_OFF_CNT, 32'h0);
        w = 3 + int'($urandom % 8);
        wr(`EPC_OFF_WRAP, 32'(w));
        wr(`EPC_OFF_DIV, 32'h1);
        wr(`EPC_OFF_CTRL, ctl(EPC_ENCODER, RUN | CLR));
        exp_cnt = 0;
        e0 = ev_n;
        t0 = tog_n;
        for (int i = 0; i < 40; i++) begin
            c = 1'($urandom % 2);
            move(1'b1, c, 1'b0);
            exp_cnt = c ? (exp_cnt == w ? 0 : exp_cnt + 1) : (exp_cnt == 0 ? w : exp_cnt - 1);
            rchk("count", `EPC_OFF_CNT, 32'(exp_cnt));
            chk("direction", {31'h0, c}, {31'h0, dir});
        end
        chk("events", 32'(e0 + 40), 32'(ev_n));
        chk("divider toggles", 32'(t0 + 20), 32'(tog_n));
        wr(`EPC_OFF_CTRL, ctl(EPC_TIMER, CLR));
        wr(`EPC_OFF_CTRL, ctl(EPC_TIMER, CAP));
        rchk("capture after clear", `EPC_OFF_CNT, 32'h0);
        wr(`EPC_OFF_CTRL, ctl(EPC_TIMER, RUN));
        wr(`EPC_OFF_CTRL, ctl(EPC_TIMER, RUN | CAP));
        rd(`EPC_OFF_CNT, d);
        wr(`EPC_OFF_CTRL, ctl(EPC_TIMER, RUN | CAP));
        rd(`EPC_OFF_CNT, d2);
        chk("capture interval", d + 32'h4, d2);
        wr(`EPC_OFF_CTRL, ctl(EPC_TIMER, RUN | ZEN));
        e0 = ev_n;
        move(1'b0, 1'b0, 1'b1);
        move(1'b0, 1'b0, 1'b0);
        chk("index capture events", 32'(e0 + 1), 32'(ev_n));
        rd(`EPC_OFF_CNT, d);
        chk("index capture", 32'h1, {31'h0, d > d2});
        wr(`EPC_OFF_CTRL, ctl(EPC_TIMER, CLR));
        wr(`EPC_OFF_CTRL, ctl(EPC_TIMER, CAP));
        rchk("capture zeroed", `EPC_OFF_CNT, 32'h0);
        @(posedge clk);
        three_ph <= 1'b1;
        repeat (3) @(posedge clk);
        wr(`EPC_OFF_CTRL, ctl(EPC_SENS_EVENT, RUN | P3 | CLR));
        move(1'b1, 1'b0, 1'b0);
        rchk("event wrap down", `EPC_OFF_CNT, 32'h0000ffff);
        repeat (6) move(1'b1, 1'b1, 1'b0);
        rchk("event wrap up", `EPC_OFF_CNT, 32'h5);
        wr(`EPC_OFF_CTRL, ctl(EPC_SENS_TIMER, RUN | P3));
        rd(`EPC_OFF_STAT, d);
        move(1'b1, 1'b1, 1'b0);
        move(1'b1, 1'b0, 1'b0);
        rd(`EPC_OFF_STAT, d);
        chk("reverse error", 32'h1, {31'h0, d[2]});
        rd(`EPC_OFF_STAT, d);
        chk("reverse error cleared", 32'h0, {31'h0, d[2]});
        // timer cleared by compare: period compare+1, one pulse per period
        wr(`EPC_OFF_CTRL, ctl(EPC_TIMER, RUN | CMPEN | CLR) | 32'h800);
        e0 = cmp_n;
        repeat (30) @(negedge clk);
        chk("compare clear pulses", 32'(e0 + 9), 32'(cmp_n));
        rchk("control", `EPC_OFF_CTRL, ctl(EPC_TIMER, RUN | CMPEN) | 32'h800);
        end_of_test();
    end
endmodule
`default_nettype wire

/* File: testbench/epc_enc_model.sv */
// Purpose: quadrature encoder and hall sensor phase source for the position counter
// Assumes: one step per request, levels move right after a rising clock edge
// Notes: hall sequence 100,110,010,011,001,101 counts as clockwise
`default_nettype none
module epc_enc_model (
    input wire logic CLK,
    input wire logic STEP,
    input wire logic CW,
    input wire logic THREE_PH,
    input wire logic IDX,
    output epc_pkg::epc_phase_t PHASE
);
    timeunit 1ns;
    timeprecision 1ps;
    import epc_pkg::*;
    localparam logic [2:0] HALL [6] = '{3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5};
    logic [2:0] pos_r = 3'h0;
    logic z_r = 1'b0;
    logic [2:0] last;
    assign last = THREE_PH ? 3'h5 : 3'h3;
    always_ff @(posedge CLK) begin
        z_r <= IDX;
        if (STEP) begin
            if (CW) begin
                pos_r <= (pos_r >= last) ? 3'h0 : pos_r + 3'h1;
            end else begin
                pos_r <= (pos_r == 3'h0) ? last : pos_r - 3'h1;
            end
        end
    end
    // encoder: a leads b clockwise, index follows its own request
    always_comb begin
        PHASE = '{a: pos_r[0] ^ pos_r[1], b: pos_r[1], z: z_r};
        if (THREE_PH) begin
            PHASE = epc_phase_t'(HALL[pos_r]);
        end
    end
endmodule
`default_nettype wire
